// ==== core/pmt8_pkg.sv ====
// Constants, register map and control layout of the 8-bit period timer.
// Assumes a single 50 MHz clock and an AXI4-Lite register slave.
//
// Function
// - The count clock is the instruction clock, system clock divided by four, passed through the prescaler.
// - Prescale select 00 divides by 1, 01 by 4, and any value with the upper bit set by 16.
// - The counter climbs from zero on each prescaler output and returns to zero on the tick after it equals the limit.
// - Counter and limit are compared all the time and every match advances the postscaler by one; the code compares them only on a prescaler tick.
// - The postscaler divides matches by postscale select plus one and each of its outputs sets the match flag.
// - Software can read and write the count and the limit at any time.
// - Reset loads the count with 00h and the limit with FFh.
// - Control bit 2 runs the timer when set and stops it when clear.
// - Prescaler and postscaler clear on a count write, a control write and on reset.
// - A control write leaves the count as it was.
// - The block holds an 8-bit count, an 8-bit limit and raises an interrupt request from the match.
package pmt8_pkg;

    // Bus geometry
    localparam int PMT8_AXI_AW = 8;
    localparam int PMT8_AXI_DW = 32;

    // Register byte addresses
    localparam logic [7:0] PMT8_OFF_COUNT = 8'h00;
    localparam logic [7:0] PMT8_OFF_LIMIT = 8'h04;
    localparam logic [7:0] PMT8_OFF_CTRL = 8'h08;
    localparam logic [7:0] PMT8_OFF_FLAGS = 8'h0C;
    localparam logic [7:0] PMT8_OFF_IEN = 8'h10;

    // Values after reset
    localparam logic [7:0] PMT8_RST_COUNT = 8'h00;
    localparam logic [7:0] PMT8_RST_LIMIT = 8'hFF;
    localparam logic [7:0] PMT8_RST_CTRL = 8'h00;
    localparam logic [3:0] PMT8_RST_POST = 4'h0;
    localparam logic [3:0] PMT8_RST_PRE = 4'h0;

    // Field positions in the flag and enable registers
    localparam int PMT8_FLAG_BIT = 1;

    // Instruction clock divider: last phase of a divide by four
    localparam logic [1:0] PMT8_INSTR_LAST = 2'h3;

    // Prescaler terminal counts (ratio minus one)
    localparam logic [3:0] PMT8_PRE_LAST_1 = 4'h0;
    localparam logic [3:0] PMT8_PRE_LAST_4 = 4'h3;
    localparam logic [3:0] PMT8_PRE_LAST_16 = 4'hF;

    // AXI responses
    localparam logic [1:0] PMT8_RESP_OKAY = 2'h0;
    localparam logic [1:0] PMT8_RESP_SLVERR = 2'h2;

    // Control register layout, bit 7 down to bit 0
    typedef struct packed {
        logic reserved;
        logic [3:0] postscale_select;
        logic period_timer_run;
        logic [1:0] prescale_select;
    } pmt8_ctrl_t;

endpackage

// ==== core/pmt8_prescale.sv ====
// Instruction clock divider and selectable prescaler of the period timer.
// Assumes one clock; emits a one-cycle tick enable toward the counter.
`timescale 1ns/10ps
module pmt8_prescale
    import pmt8_pkg::*;
(
    input wire logic aclk, // System clock
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic clr, // Clear prescaler count
    input wire logic run, // Timer running
    input wire logic [1:0] sel, // Prescale select
    output logic tick // One-cycle count enable
);

    logic [1:0] instr_ff;
    logic [3:0] pre_ff;
    logic [3:0] pre_last;
    logic instr_en;
    logic pre_done;

    // Instruction clock runs free, like the core's own machine cycle
    // divide by four
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            instr_ff <= 2'h0;
        else
            instr_ff <= instr_ff + 2'h1;
    end

    assign instr_en = (instr_ff == PMT8_INSTR_LAST);

    // Terminal count from the select field
    // ratio decode
    always_comb
    begin
        if (sel[1])
            pre_last = PMT8_PRE_LAST_16;
        else if (sel[0])
            pre_last = PMT8_PRE_LAST_4;
        else
            pre_last = PMT8_PRE_LAST_1;
    end

    assign pre_done = (pre_ff >= pre_last);

    // Prescale counter, cleared by register writes
    // prescaler clear
    always_ff @(posedge aclk)
    begin
        if (!aresetn || clr)
            pre_ff <= PMT8_RST_PRE;
        else if (run && instr_en)
            pre_ff <= pre_done ? PMT8_RST_PRE : pre_ff + 4'h1;
    end

    // Suppressed during a clear so a write never races a tick
    assign tick = run && instr_en && pre_done && !clr;

endmodule

// ==== core/pmt8_timer.sv ====
// Top of the 8-bit period timer: AXI4-Lite slave, counter, postscaler
// and match flag. Assumes one 50 MHz clock and a synchronous reset.
//
// Register access over AXI4-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
module pmt8_timer
    import pmt8_pkg::*;
(
    input wire logic aclk, // System clock
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic [PMT8_AXI_AW-1:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [PMT8_AXI_DW-1:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [PMT8_AXI_AW-1:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [PMT8_AXI_DW-1:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    output logic period_match_irq // Flag and enable, level
);

    // Write channel holding registers
    logic aw_held_ff;
    logic w_held_ff;
    logic [7:0] aw_addr_ff;
    logic [7:0] w_data_ff;
    logic w_lane0_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;

    // Read channel registers
    logic rvalid_ff;
    logic [PMT8_AXI_DW-1:0] rdata_ff;
    logic [1:0] rresp_ff;

    // Timer state
    logic [7:0] period_count_ff;
    logic [7:0] period_limit_ff;
    pmt8_ctrl_t ctrl_ff;
    logic [3:0] post_ff;
    logic period_match_flag_ff;
    logic period_match_irq_enable_ff;

    // Decoded strobes and events
    logic wr_fire;
    logic wr_en;
    logic [7:0] wr_addr;
    logic [7:0] rd_addr;
    logic wr_mapped;
    logic we_count;
    logic we_limit;
    logic we_ctrl;
    logic we_flags;
    logic we_ien;
    logic scaler_clr;
    logic tick;
    logic match;
    logic post_out;
    logic ar_fire;
    logic [7:0] rd_value;
    logic rd_mapped;

    // AXI4-Lite write side

    // Address and data are taken in either order and held
    assign s_axi_awready = !aw_held_ff;
    assign s_axi_wready = !w_held_ff;

    // Address holding register, freed when the write acts
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_ff <= 1'b0;
            aw_addr_ff <= 8'h00;
        end
        else if (s_axi_awvalid && !aw_held_ff)
        begin
            aw_held_ff <= 1'b1;
            aw_addr_ff <= s_axi_awaddr;
        end
        else if (wr_fire)
            aw_held_ff <= 1'b0;
    end

    // Data holding register; only the low byte and lane matter
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_held_ff <= 1'b0;
            w_data_ff <= 8'h00;
            w_lane0_ff <= 1'b0;
        end
        else if (s_axi_wvalid && !w_held_ff)
        begin
            w_held_ff <= 1'b1;
            w_data_ff <= s_axi_wdata[7:0];
            w_lane0_ff <= s_axi_wstrb[0];
        end
        else if (wr_fire)
            w_held_ff <= 1'b0;
    end

    // Write acts once both halves are in and no response is pending
    assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;
    // Lane bits of the address are ignored
    assign wr_addr = {aw_addr_ff[7:2], 2'b00};
    // A cleared low strobe turns the write into a no-op
    assign wr_en = wr_fire && w_lane0_ff;

    // One write strobe per register
    assign we_count = wr_en && (wr_addr == PMT8_OFF_COUNT);
    assign we_limit = wr_en && (wr_addr == PMT8_OFF_LIMIT);
    assign we_ctrl = wr_en && (wr_addr == PMT8_OFF_CTRL);
    assign we_flags = wr_en && (wr_addr == PMT8_OFF_FLAGS);
    assign we_ien = wr_en && (wr_addr == PMT8_OFF_IEN);

    // Any other word is answered with an error
    assign wr_mapped = (wr_addr == PMT8_OFF_COUNT)
                    || (wr_addr == PMT8_OFF_LIMIT)
                    || (wr_addr == PMT8_OFF_CTRL)
                    || (wr_addr == PMT8_OFF_FLAGS)
                    || (wr_addr == PMT8_OFF_IEN);

    // Response; unmapped addresses answer SLVERR and change nothing
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_ff <= 1'b0;
            bresp_ff <= PMT8_RESP_OKAY;
        end
        else if (wr_fire)
        begin
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_mapped ? PMT8_RESP_OKAY : PMT8_RESP_SLVERR;
        end
        else if (s_axi_bready)
            bvalid_ff <= 1'b0;
    end

    // Write answer straight from its registers
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;

    // AXI4-Lite read side

    // One read in flight; address refused while data waits
    assign s_axi_arready = !rvalid_ff;
    assign ar_fire = s_axi_arvalid && !rvalid_ff;
    assign rd_addr = {s_axi_araddr[7:2], 2'b00};

    // Read mux shows live timer state
    // readable count and limit
    always_comb
    begin
        rd_mapped = 1'b1;
        rd_value = 8'h00;
        unique case (rd_addr)
            PMT8_OFF_COUNT: rd_value = period_count_ff;
            PMT8_OFF_LIMIT: rd_value = period_limit_ff;
            PMT8_OFF_CTRL: rd_value = ctrl_ff;
            PMT8_OFF_FLAGS:
                rd_value[PMT8_FLAG_BIT] = period_match_flag_ff;
            PMT8_OFF_IEN:
                rd_value[PMT8_FLAG_BIT] = period_match_irq_enable_ff;
            default: rd_mapped = 1'b0;
        endcase
    end

    // Answer registered; state is sampled at the accepting edge
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= PMT8_RESP_OKAY;
        end
        else if (ar_fire)
        begin
            rvalid_ff <= 1'b1;
            rdata_ff <= {24'h00_0000, rd_value};
            rresp_ff <= rd_mapped ? PMT8_RESP_OKAY : PMT8_RESP_SLVERR;
        end
        else if (s_axi_rready)
            rvalid_ff <= 1'b0;
    end

    // Read answer straight from its registers
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;

    // Timer core

    // Control and count writes restart both scalers
    // scaler clear sources
    assign scaler_clr = we_count || we_ctrl;

    pmt8_prescale u_prescale
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .clr(scaler_clr),
        .run(ctrl_ff.period_timer_run),
        .sel(ctrl_ff.prescale_select),
        .tick(tick)
    );

    // Comparator is only sampled on a tick, so a stopped timer
    // cannot produce a match
    // compare on a tick
    assign match = tick && (period_count_ff == period_limit_ff);

    // Control register; reserved bit kept at zero
    // run bit
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            ctrl_ff <= PMT8_RST_CTRL;
        else if (we_ctrl)
            ctrl_ff <= {1'b0, w_data_ff[6:0]};
    end

    // Period limit
    // limit reset to FFh
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            period_limit_ff <= PMT8_RST_LIMIT;
        else if (we_limit)
            period_limit_ff <= w_data_ff;
    end

    // Counter; a software write wins over a tick in the same cycle
    // count reset to 00h
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            period_count_ff <= PMT8_RST_COUNT;
        else if (we_count)
            period_count_ff <= w_data_ff;
        else if (match)
            period_count_ff <= PMT8_RST_COUNT;
        else if (tick)
            period_count_ff <= period_count_ff + 8'h01;
    end
    // control writes never touch the count above

    // Postscaler output on the match that completes the ratio
    // divide by select plus one
    assign post_out = match && (post_ff == ctrl_ff.postscale_select);

    // Postscale counter, restarted together with the prescaler
    always_ff @(posedge aclk)
    begin
        if (!aresetn || scaler_clr)
            post_ff <= PMT8_RST_POST;
        else if (match)
            post_ff <= post_out ? PMT8_RST_POST : post_ff + 4'h1;
    end

    // Match flag: hardware set beats a software clear
    // flag set
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            period_match_flag_ff <= 1'b0;
        else if (post_out)
            period_match_flag_ff <= 1'b1;
        else if (we_flags)
            period_match_flag_ff <= w_data_ff[PMT8_FLAG_BIT];
    end

    // Interrupt enable, written by software only
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            period_match_irq_enable_ff <= 1'b0;
        else if (we_ien)
            period_match_irq_enable_ff <= w_data_ff[PMT8_FLAG_BIT];
    end

    // Request is a level; software clears the flag or the enable to drop it
    // interrupt request
    assign period_match_irq = period_match_flag_ff
                           && period_match_irq_enable_ff;

endmodule

// ==== bench/pmt8_properties.sv ====
// Port checker of the period timer: bus answers and reset state.
// Assumes it is bound to every pmt8_timer instance.
`timescale 1ns/10ps
module pmt8_checker
    import pmt8_pkg::*;
(
    input wire logic aclk, // Clock
    input wire logic aresetn, // Reset
    input wire logic s_axi_awvalid, // In
    input wire logic s_axi_awready, // Out
    input wire logic s_axi_wvalid, // In
    input wire logic s_axi_wready, // Out
    input wire logic [1:0] s_axi_bresp, // Out
    input wire logic s_axi_bvalid, // Out
    input wire logic s_axi_bready, // In
    input wire logic [PMT8_AXI_AW-1:0] s_axi_araddr, // In
    input wire logic s_axi_arvalid, // In
    input wire logic s_axi_arready, // Out
    input wire logic [PMT8_AXI_DW-1:0] s_axi_rdata, // Out
    input wire logic [1:0] s_axi_rresp, // Out
    input wire logic s_axi_rvalid, // Out
    input wire logic s_axi_rready, // In
    input wire logic period_match_irq // Out
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Answers keep their timing and stand until taken
    AST_READ_ANSWER:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    AST_WRITE_ANSWER:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready && !s_axi_bvalid |-> ##2 s_axi_bvalid)
        else $error("write not answered");
    AST_READ_HOLD:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read data dropped");
    AST_WRITE_HOLD:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("write answer dropped");
    AST_BYTE_WIDE:
    assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
        else $error("upper read bits set");
    AST_UNMAPPED:
    assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr >=
        8'h14 |=> s_axi_rresp == PMT8_RESP_SLVERR && s_axi_rdata == 0)
        else $error("unmapped read answered wrongly");
    AST_MAPPED:
    assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr <
        8'h14 |=> s_axi_rresp == PMT8_RESP_OKAY)
        else $error("mapped read refused");
    // Reset itself is the cause here, so it cannot disable the check
    AST_RESET_QUIET:
    assert property (disable iff (1'b0) !aresetn |=> !s_axi_bvalid
        && !s_axi_rvalid && !period_match_irq)
        else $error("outputs busy after reset");
endmodule
bind pmt8_timer pmt8_checker i_chk (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .period_match_irq(period_match_irq));

// ==== bench/tb.sv ====
// Self-checking bench of the period timer over its register bus.
// Assumes the checker is bound in; expectations follow the timer rules.
`timescale 1ns/10ps
`define CHK(nm, e, g) \
    begin \
        total_checks++; \
        if ((g) !== (e)) \
        begin \
            n_fail++; \
            $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); \
        end \
    end
module tb
    import pmt8_pkg::*;
;
    logic aclk, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
    logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000, rdata;
    logic [3:0] wstrb = 4'hF;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp;
    int n_fail = 0, total_checks = 0;
    pmt8_timer i_dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .period_match_irq(irq));
    // Clock; sampling at the falling edge avoids edge races
    initial
    begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    task automatic wr(input logic [7:0] a, d, input logic [1:0] er);
        logic aw_t, w_t, b_t;
        logic [1:0] r;
        begin
            b_t = 1'b0;
            awaddr <= a;
            wdata <= {24'h00_0000, d};
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            while (!b_t)
            begin
                @(negedge aclk);
                aw_t = awvalid && awready;
                w_t = wvalid && wready;
                b_t = bvalid;
                r = bresp;
                @(posedge aclk);
                if (aw_t)
                    awvalid <= 1'b0;
                if (w_t)
                    wvalid <= 1'b0;
            end
            bready <= 1'b0;
            // One idle edge so a next call never reassigns bready
            @(posedge aclk);
            `CHK("bresp", er, r)
        end
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
        output logic [1:0] r);
        logic ar_t, r_t;
        begin
            r_t = 1'b0;
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
            while (!r_t)
            begin
                @(negedge aclk);
                ar_t = arvalid && arready;
                r_t = rvalid;
                d = rdata;
                r = rresp;
                @(posedge aclk);
                if (ar_t)
                    arvalid <= 1'b0;
            end
            rready <= 1'b0;
            // One idle edge so a next call never reassigns rready
            @(posedge aclk);
        end
    endtask
    task automatic crd(input logic [7:0] a, e, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        begin
            rd(a, d, r);
            `CHK("rdata", {24'h00_0000, e}, d)
            `CHK("rresp", er, r)
        end
    endtask
    task automatic cirq(input logic e);
        begin
            @(negedge aclk);
            `CHK("irq", e, irq)
            @(posedge aclk);
        end
    endtask
    task automatic t_regs();
        begin
            crd(PMT8_OFF_COUNT, 8'h00, PMT8_RESP_OKAY);
            crd(PMT8_OFF_LIMIT, 8'hFF, PMT8_RESP_OKAY);
            wr(PMT8_OFF_LIMIT, 8'h5A, PMT8_RESP_OKAY);
            crd(PMT8_OFF_LIMIT, 8'h5A, PMT8_RESP_OKAY);
            // Low lane strobe clear: answered, but nothing is written
            wstrb <= 4'h0;
            wr(PMT8_OFF_LIMIT, 8'h33, PMT8_RESP_OKAY);
            wstrb <= 4'hF;
            crd(PMT8_OFF_LIMIT, 8'h5A, PMT8_RESP_OKAY);
            wr(PMT8_OFF_COUNT, 8'hA5, PMT8_RESP_OKAY);
            repeat (100) @(posedge aclk);
            crd(PMT8_OFF_COUNT, 8'hA5, PMT8_RESP_OKAY);
            wr(8'h20, 8'h11, PMT8_RESP_SLVERR);
            crd(8'h20, 8'h00, PMT8_RESP_SLVERR);
            $display("test regs done");
        end
    endtask
    // Count write must restart the 1:16 prescaler, else a tick lands
    task automatic t_clear();
        begin
            wr(PMT8_OFF_CTRL, 8'h06, PMT8_RESP_OKAY);
            repeat (40) @(posedge aclk);
            wr(PMT8_OFF_COUNT, 8'h10, PMT8_RESP_OKAY);
            repeat (50) @(posedge aclk);
            crd(PMT8_OFF_COUNT, 8'h10, PMT8_RESP_OKAY);
            wr(PMT8_OFF_CTRL, 8'h06, PMT8_RESP_OKAY);
            crd(PMT8_OFF_COUNT, 8'h10, PMT8_RESP_OKAY);
            $display("test clear done");
        end
    endtask
    // Eight ticks at each ratio; phase of the divider allows one either way
    task automatic t_rate();
        logic [31:0] d;
        logic [1:0] r;
        int k;
        begin
            for (int s = 0; s < 4; s++)
            begin
                k = s[1] ? 16 : (s[0] ? 4 : 1);
                wr(PMT8_OFF_CTRL, 8'h00, PMT8_RESP_OKAY);
                wr(PMT8_OFF_COUNT, 8'h00, PMT8_RESP_OKAY);
                wr(PMT8_OFF_CTRL, 8'h04 | 8'(s), PMT8_RESP_OKAY);
                repeat (32 * k) @(posedge aclk);
                rd(PMT8_OFF_COUNT, d, r);
                `CHK("rate", 1'b1, d >= 7 && d <= 9)
            end
            // Clearing the run bit, with postscale F and prescale 1:1, freezes a loaded count
            wr(PMT8_OFF_CTRL, 8'h78, PMT8_RESP_OKAY);
            wr(PMT8_OFF_COUNT, 8'h42, PMT8_RESP_OKAY);
            repeat (300) @(posedge aclk);
            crd(PMT8_OFF_COUNT, 8'h42, PMT8_RESP_OKAY);
            $display("test rate done");
        end
    endtask
    // Limit 3 at 1:1 gives a match every 16 clocks
    task automatic t_post(input logic [3:0] p);
        int t;
        logic [31:0] d;
        logic [1:0] r;
        begin
            t = 16 * (p + 1);
            wr(PMT8_OFF_CTRL, 8'h00, PMT8_RESP_OKAY);
            wr(PMT8_OFF_LIMIT, 8'h03, PMT8_RESP_OKAY);
            wr(PMT8_OFF_COUNT, 8'h00, PMT8_RESP_OKAY);
            wr(PMT8_OFF_IEN, 8'h02, PMT8_RESP_OKAY);
            wr(PMT8_OFF_FLAGS, 8'h00, PMT8_RESP_OKAY);
            wr(PMT8_OFF_CTRL, {1'b0, p, 3'h4}, PMT8_RESP_OKAY);
            repeat (t - 8) @(posedge aclk);
            cirq(1'b0);
            repeat (12) @(posedge aclk);
            cirq(1'b1);
            wr(PMT8_OFF_IEN, 8'h00, PMT8_RESP_OKAY);
            cirq(1'b0);
            crd(PMT8_OFF_FLAGS, 8'h02, PMT8_RESP_OKAY);
            // Limit 3 keeps the running count within 0 to 3
            rd(PMT8_OFF_COUNT, d, r);
            `CHK("wrap", 1'b1, d <= 32'h0000_0003)
            wr(PMT8_OFF_FLAGS, 8'h00, PMT8_RESP_OKAY);
            $display("test post %0d done", p);
        end
    endtask
    // Reset in mid-run brings back the values after reset
    task automatic t_reset();
        begin
            wr(PMT8_OFF_LIMIT, 8'h21, PMT8_RESP_OKAY);
            wr(PMT8_OFF_COUNT, 8'h44, PMT8_RESP_OKAY);
            aresetn <= 1'b0;
            repeat (3) @(posedge aclk);
            aresetn <= 1'b1;
            @(posedge aclk);
            crd(PMT8_OFF_COUNT, 8'h00, PMT8_RESP_OKAY);
            crd(PMT8_OFF_LIMIT, 8'hFF, PMT8_RESP_OKAY);
            $display("test reset done");
        end
    endtask
    task automatic finish_test();
        begin
            $display("checks %0d failures %0d", total_checks, n_fail);
            if (n_fail == 0 && total_checks > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    // Watchdog well beyond the expected run of some 2300 clocks
    initial
    begin
        repeat (30000) @(posedge aclk);
        n_fail++;
        finish_test();
    end
    initial
    begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_regs();
        t_clear();
        t_rate();
        t_post(4'h0);
        t_post(4'h1);
        t_post(4'hF);
        t_reset();
        finish_test();
    end
endmodule
